// [inc/sdb_pkg.sv]
package sdb_pkg;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] CNT_RST = 8'h04;
  localparam int unsigned STEP_W = 4;
  // staged sequence: last step_cnt value; reset, clock, data and supply steps come STAGE_TICKS + 1 ticks apart
  localparam logic [3:0] STAGE_TICKS = 4'h1;

  typedef enum logic [2:0] {
    SDB_IDLE,
    SDB_INSTANT,
    SDB_ST_RST,
    SDB_ST_CLK,
    SDB_ST_DATA,
    SDB_ST_VCC,
    SDB_DONE
  } sdb_state_type;

  // slot line controls; supply_en powers the slot, the other three bits park its lines
  typedef struct packed {
    logic supply_en;
    logic rst_hold_low;
    logic clk_stop;
    logic data_low;
  } sdb_slot_type;

  // slot two line patterns: powered and free, and fully shut down
  localparam sdb_slot_type SLOT_ON = 4'h8;
  localparam sdb_slot_type SLOT_OFF = 4'h7;

  typedef struct packed {
    logic [1:0] pin_sync;
    logic [7:0] debounce_counter;
    logic shutdown_request_qualified;
    sdb_state_type state;
    logic [3:0] step_cnt;
    sdb_slot_type slot2;
    logic busy;
  } sdb_regs_type;

endpackage

// [logic/sdb_shutdown_debounce.sv]
module sdb_shutdown_debounce #(
  parameter int unsigned CNT_W = sdb_pkg::CNT_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // timing clock enable, one pulse per low-frequency tick
  input wire logic tick_i,
  // pin and configuration
  input wire logic shutdown_request_pin_i,
  input wire logic detect_level_i,
  input wire logic [7:0] debounce_count_i,
  // slot two status
  input wire logic slot2_powered_i,
  input wire logic slot2_active_i,
  input wire logic host_card_clock_running_i,
  // results
  output logic shutdown_request_qualified_o,
  output logic slot2_shutdown_busy_o,
  output sdb_pkg::sdb_slot_type slot2_ctrl_o
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the counter field of the state struct is fixed at eight bits
  if (CNT_W != 8) begin : g_cnt_w_chk
    $error("sdb: counter width must be 8");
  end

  // stage pacing counter is four bits in the state struct
  if (sdb_pkg::STEP_W != 4) begin : g_step_w_chk
    $error("sdb: step counter width must be 4");
  end

  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  sdb_pkg::sdb_regs_type s_r;
  sdb_pkg::sdb_regs_type s_nxt;
  logic pin_active;
  logic stage_adv;
  logic qual_rise;
  logic stage_req;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    pin_active = 1'b0;
    stage_adv = 1'b0;
    qual_rise = 1'b0;
    stage_req = 1'b0;

    // ----------------------------------------
    // pin synchroniser and debounce
    // ----------------------------------------
    // second flop is the only reader of the first
    s_nxt.pin_sync = {s_r.pin_sync[0], shutdown_request_pin_i};

    // level setting read live; a change mid-debounce just retargets
    pin_active = (s_r.pin_sync[1] == detect_level_i);

    if (tick_i) begin
      if (!pin_active) begin
        // no latch-up: qualified follows the pin back once it leaves
        s_nxt.debounce_counter = debounce_count_i;
        s_nxt.shutdown_request_qualified = 1'b0;
      end else if (s_r.debounce_counter > 8'h01) begin
        s_nxt.debounce_counter = s_r.debounce_counter - 8'h01;
      end else begin
        // counts of 0 and 1 both qualify on the first active tick
        s_nxt.debounce_counter = 8'h00;
        s_nxt.shutdown_request_qualified = 1'b1;
      end
    end

    // ----------------------------------------
    // stage pacing
    // ----------------------------------------
    stage_adv = tick_i && (s_r.step_cnt == sdb_pkg::STAGE_TICKS);

    if (tick_i) begin
      if (stage_adv) begin
        s_nxt.step_cnt = 4'h0;
      end else begin
        s_nxt.step_cnt = s_r.step_cnt + 4'h1;
      end
    end

    // ----------------------------------------
    // slot two sequence
    // ----------------------------------------
    qual_rise = s_nxt.shutdown_request_qualified && !s_r.shutdown_request_qualified;

    // staged only for a card that is talking with its clock running
    stage_req = slot2_active_i && host_card_clock_running_i;

    // slot one has no path here at all
    case (s_r.state)
      sdb_pkg::SDB_IDLE: begin
        s_nxt.busy = 1'b0;
        // rising of qualified with slot two powered starts one sequence, no host command needed
        if (qual_rise && slot2_powered_i) begin
          s_nxt.busy = 1'b1;
          s_nxt.step_cnt = 4'h0;
          if (stage_req) begin
            s_nxt.state = sdb_pkg::SDB_ST_RST;
          end else begin
            s_nxt.state = sdb_pkg::SDB_INSTANT;
          end
        end
      end

      sdb_pkg::SDB_INSTANT: begin
        // all lines low and supply off together
        s_nxt.slot2 = sdb_pkg::SLOT_OFF;
        s_nxt.state = sdb_pkg::SDB_DONE;
      end

      sdb_pkg::SDB_ST_RST: begin
        // reset first so the card sees no clock edges unreset
        s_nxt.slot2.rst_hold_low = 1'b1;
        if (stage_adv) begin
          s_nxt.state = sdb_pkg::SDB_ST_CLK;
        end
      end

      sdb_pkg::SDB_ST_CLK: begin
        s_nxt.slot2.clk_stop = 1'b1;
        if (stage_adv) begin
          s_nxt.state = sdb_pkg::SDB_ST_DATA;
        end
      end

      sdb_pkg::SDB_ST_DATA: begin
        s_nxt.slot2.data_low = 1'b1;
        if (stage_adv) begin
          s_nxt.state = sdb_pkg::SDB_ST_VCC;
        end
      end

      sdb_pkg::SDB_ST_VCC: begin
        // supply last, once every line is already parked low
        s_nxt.slot2.supply_en = 1'b0;
        s_nxt.state = sdb_pkg::SDB_DONE;
      end

      sdb_pkg::SDB_DONE: begin
        // pin release does not abort; rearm once qualified drops
        s_nxt.busy = 1'b0;
        if (!s_r.shutdown_request_qualified) begin
          s_nxt.state = sdb_pkg::SDB_IDLE;
          s_nxt.slot2 = sdb_pkg::SLOT_ON;
        end
      end

      default: begin
        s_nxt.state = sdb_pkg::SDB_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_r <= '{pin_sync: 2'b00,
               debounce_counter: sdb_pkg::CNT_RST,
               shutdown_request_qualified: 1'b0,
               state: sdb_pkg::SDB_IDLE,
               step_cnt: 4'h0,
               slot2: sdb_pkg::SLOT_ON,
               busy: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign shutdown_request_qualified_o = s_r.shutdown_request_qualified;
  assign slot2_shutdown_busy_o = s_r.busy;
  assign slot2_ctrl_o = s_r.slot2;

endmodule

// [test/sdb_monitor.sv]
module sdb_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // stimulus
  input wire logic tick_i,
  input wire logic slot2_powered_i,
  input wire logic slot2_active_i,
  input wire logic host_card_clock_running_i,
  // results
  input wire logic shutdown_request_qualified_o,
  input wire logic slot2_shutdown_busy_o,
  input wire sdb_pkg::sdb_slot_type slot2_ctrl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rise_s; $rose(shutdown_request_qualified_o); endsequence
  sequence inst_s;
    rise_s ##0 slot2_powered_i && !(slot2_active_i && host_card_clock_running_i);
  endsequence
  sequence stg_s;
    rise_s ##0 slot2_powered_i && slot2_active_i && host_card_clock_running_i;
  endsequence
  rise_tick_a: assert property (rise_s |-> $past(tick_i)) else $error("rise off tick");
  fall_tick_a: assert property ($fell(shutdown_request_qualified_o) |-> $past(tick_i))
    else $error("drop off tick");
  start_busy_a: assert property (rise_s ##0 slot2_powered_i |-> slot2_shutdown_busy_o)
    else $error("no start");
  no_power_a: assert property (rise_s ##0 !slot2_powered_i |=>
    !slot2_shutdown_busy_o && slot2_ctrl_o == 4'h8) else $error("unpowered run");
  instant_off_a: assert property (inst_s |=> slot2_ctrl_o == 4'h7 ##1
    !slot2_shutdown_busy_o) else $error("instant bad");
  staged_off_a: assert property (stg_s |=> slot2_ctrl_o == 4'hc ##1
    slot2_shutdown_busy_o && slot2_ctrl_o == 4'hc) else $error("staged bad");
  supply_cut_a: assert property ($fell(slot2_ctrl_o.supply_en) |->
    slot2_shutdown_busy_o) else $error("cut outside run");
  supply_back_a: assert property ($rose(slot2_ctrl_o.supply_en) |->
    !shutdown_request_qualified_o) else $error("early restore");
endmodule

// [test/sdb_host_model.sv]
module sdb_host_model (
  input wire logic act_i,
  input wire logic level_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // host drives the opposite level when idle, never floats
  assign pin_o = act_i ? level_i : ~level_i;
endmodule

// [test/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_n_i = 0, tick_i = 0, act = 0, lvl = 0, pwr = 0, actv = 0, run = 0;
  logic [7:0] cnt = 8'h04;
  logic pin, q, busy;
  sdb_pkg::sdb_slot_type ctrl;
  int errors = 0, n_checks = 0, k, n;
  always #2 mclk_i = ~mclk_i;
  sdb_host_model HOST (.act_i(act), .level_i(lvl), .pin_o(pin));
  sdb_shutdown_debounce DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tick_i(tick_i),
    .shutdown_request_pin_i(pin), .detect_level_i(lvl), .debounce_count_i(cnt),
    .slot2_powered_i(pwr), .slot2_active_i(actv), .host_card_clock_running_i(run),
    .shutdown_request_qualified_o(q), .slot2_shutdown_busy_o(busy), .slot2_ctrl_o(ctrl));
  task chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ticks(input int t);
    repeat (t) begin
      @(posedge mclk_i) #1 tick_i = 1;
      @(posedge mclk_i) #1 tick_i = 0;
    end
  endtask
  // three edges so the two sync flops settle
  task setp(input logic v);
    act = v;
    repeat (3) @(posedge mclk_i);
  endtask
  function automatic logic [3:0] ctrl_exp(input logic p, input logic a, input logic r);
    return !p ? 4'h8 : (a && r) ? 4'hc : 4'h7;
  endfunction
  task test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // corner counts 4,2,1,0 first, then random
  // ----------------------------------------
  initial begin
    k = $urandom(40322);
    repeat (8) @(posedge mclk_i);
    #1 rst_n_i = 1;
    for (int i = 0; i < 8; i++) begin
      lvl = i[2];
      pwr = (i != 2);
      actv = i[0] | 1'($urandom);
      run = i[0] | i[1];
      cnt = (i < 4) ? 8'(4 >> i) : 8'($urandom_range(9, 2));
      n = (cnt <= 1) ? 1 : int'(cnt);
      // settle the new level, then one idle tick loads the new count
      setp(0);
      ticks(1);
      setp(1);
      if (n > 1) begin
        ticks(n - 1);
        setp(0);
        ticks(1);
        chk(4'(q), 4'h0);
        setp(1);
      end
      ticks(n - 1);
      chk(4'(q), 4'h0);
      ticks(1);
      chk(4'(q), 4'h1);
      @(posedge mclk_i) #1 chk(ctrl, ctrl_exp(pwr, actv, run));
      chk(4'(busy), 4'(pwr));
      k = 0;
      while (busy === 1'b1 && k < 60) begin
        ticks(1);
        k++;
      end
      chk(4'(busy), 4'h0);
      chk(ctrl, pwr ? 4'h7 : 4'h8);
      setp(0);
      ticks(1);
      @(posedge mclk_i) #1 chk(4'(q), 4'h0);
      chk(ctrl, 4'h8);
    end
    test_done;
  end
  initial begin
    #100000;
    errors++;
    test_done;
  end
endmodule
bind sdb_shutdown_debounce sdb_monitor MON (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .tick_i(tick_i), .slot2_powered_i(slot2_powered_i), .slot2_active_i(slot2_active_i),
  .host_card_clock_running_i(host_card_clock_running_i),
  .shutdown_request_qualified_o(shutdown_request_qualified_o),
  .slot2_shutdown_busy_o(slot2_shutdown_busy_o), .slot2_ctrl_o(slot2_ctrl_o));
